// file: logic/wit_pkg.sv
// Shared constants for the wake-up interval timer.
// Assumes an 8-bit special-function register port on the core side.
package wit_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] WIT_ADDR_CTRL    = 8'hA1;
    localparam logic [7:0] WIT_ADDR_HTHSEC  = 8'hA2;
    localparam logic [7:0] WIT_ADDR_SEC     = 8'hA3;
    localparam logic [7:0] WIT_ADDR_MIN     = 8'hA4;
    localparam logic [7:0] WIT_ADDR_HOUR    = 8'hA5;
    localparam logic [7:0] WIT_ADDR_COMPARE = 8'hA6;
    // ==========================================================
    // Control register fields and reset values
    localparam int         WIT_BIT_TIME_CLOCK_ENABLE   = 0;
    localparam int         WIT_BIT_INTERVAL_COUNT_ENABLE   = 1;
    localparam int         WIT_BIT_FLAG   = 2;
    localparam int         WIT_BIT_STI    = 3;
    localparam int         WIT_BIT_TBLO   = 4;
    localparam int         WIT_BIT_TFH    = 6;
    localparam logic [7:0] WIT_CTRL_RESET = 8'h00;
    localparam logic [7:0] WIT_REG_RESET  = 8'h00;
    // ==========================================================
    // Counting limits
    localparam int         WIT_XTAL_HZ     = 32768;
    localparam int         WIT_TICK_HZ     = 128;
    localparam logic [7:0] WIT_PRESCALE_MAX = 8'((WIT_XTAL_HZ / WIT_TICK_HZ) - 1);
    localparam logic [7:0] WIT_HTH_MAX     = 8'h7F;
    localparam logic [7:0] WIT_SEC_MAX     = 8'h3B;
    localparam logic [7:0] WIT_HOUR24_MAX  = 8'h17;
    localparam logic [7:0] WIT_HOUR_MAX    = 8'hFF;
    localparam logic [15:0] WIT_WAKE_VECTOR = 16'h0053;
    // Stage indices of the time chain
    localparam int         WIT_STAGES     = 4;
    localparam int         WIT_STG_HOUR   = 3;
endpackage

// file: logic/wit_time_if.sv
// Carrier between the timer control logic and its time-of-day chain.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface wit_time_if;
    logic       xtick;          // One crystal edge
    logic       run;            // Time clock enable
    logic       twenty_four_hour_select;            // Twenty-four hour wrap
    logic [7:0] shadow [4];     // Last software-written time values
    logic [3:0] ld;             // Load one stage while running
    logic [7:0] ld_val;         // Value for that load
    logic [7:0] count  [4];     // Live time-of-day counts
    logic [3:0] ovf;            // 1/128 s tick and wraps of stages 0 to 2
    modport chain (input xtick, run, twenty_four_hour_select, shadow, ld, ld_val, output count, ovf);
    modport ctl   (output xtick, run, twenty_four_hour_select, shadow, ld, ld_val, input count, ovf);
endinterface

// file: logic/wit_time_chain.sv
// Prescaler and hundred-twenty-eighths/seconds/minutes/hours chain.
// Assumes xtick is a one-cycle pulse per crystal edge.
`timescale 1ns/10ps
module wit_time_chain
    import wit_pkg::*;
(
    // Clock and reset
    input  wire logic  mclk_in,
    input  wire logic  rstn_in,
    // Control side
    wit_time_if.chain  tif
);
    logic [7:0] presc_reg;
    logic [4:0] carry;
    logic [7:0] limit [4];

    // ==========================================================
    // Crystal prescaler, 1/128 s tick
    assign carry[0] = tif.xtick && tif.run && (presc_reg == WIT_PRESCALE_MAX);
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            presc_reg <= WIT_REG_RESET;
        end else if (!tif.run) begin
            presc_reg <= WIT_REG_RESET;
        end else if (tif.xtick) begin
            presc_reg <= presc_reg + 8'h01;
        end
    end

    // Stage wrap values
    assign limit[0] = WIT_HTH_MAX;
    assign limit[1] = WIT_SEC_MAX;
    assign limit[2] = WIT_SEC_MAX;
    assign limit[3] = tif.twenty_four_hour_select ? WIT_HOUR24_MAX : WIT_HOUR_MAX;

    // ==========================================================
    // Counter stages
    genvar i;
    generate
        for (i = 0; i < WIT_STAGES; i++) begin : g_stage
            assign carry[i+1] = carry[i] && (tif.count[i] == limit[i]);
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    tif.count[i] <= WIT_REG_RESET;
                end else if (!tif.run) begin
                    tif.count[i] <= tif.shadow[i];
                end else if (tif.ld[i]) begin
                    tif.count[i] <= tif.ld_val;
                end else if (carry[i]) begin
                    tif.count[i] <= (tif.count[i] == limit[i]) ? WIT_REG_RESET : tif.count[i] + 8'h01;
                end
            end
        end
    endgenerate

    // Overflows offered to the interval counter
    assign tif.ovf = carry[3:0];

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    chk_stopped_restore: assert property (!tif.run |=> tif.count[0] == $past(tif.shadow[0]))
        else $error("stopped counter not restored");
    chk_hour_wrap_24: assert property (tif.run && tif.twenty_four_hour_select && carry[WIT_STG_HOUR] && !tif.ld[WIT_STG_HOUR]
        && tif.count[WIT_STG_HOUR] == WIT_HOUR24_MAX |=> tif.count[WIT_STG_HOUR] == 8'h00)
        else $error("hour did not wrap at 23");
    chk_tick_spacing: assert property (carry[0] |=> !carry[0] [*8])
        else $error("1/128 s ticks too close");
endmodule

// file: logic/wit_timer.sv
// Wake-up interval timer: control register, time registers, interval counter.
// Assumes a synchronous SFR port and a crystal level sampled on mclk_in.
`timescale 1ns/10ps
module wit_timer
    import wit_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // Crystal level
    input  wire logic        xtal_in,
    // SFR port
    input  wire logic [7:0]  sfr_addr_in,
    input  wire logic [7:0]  sfr_wdata_in,
    input  wire logic        sfr_wr_in,
    input  wire logic        sfr_rd_in,
    output logic      [7:0]  sfr_rdata_out,
    output logic             sfr_busy_out,
    // Core status
    input  wire logic        irq_enable_in,
    input  wire logic        power_down_in,
    // Interrupt and wake
    output logic             irq_out,
    output logic             wake_out,
    output logic      [15:0] wake_vector_out
);
    wit_time_if tif ();

    logic       xtal_prev_reg;
    logic       xtick;
    logic       pend_reg;
    logic [7:0] pend_addr_reg;
    logic [7:0] pend_data_reg;
    logic       apply;
    logic [7:0] ctrl_reg;
    logic [7:0] compare_reg;
    logic [7:0] icnt_reg;
    logic [7:0] shadow_reg [4];
    logic       step;
    logic       match;
    logic       flag_clr;
    logic [7:0] rd_mux;

    // ==========================================================
    // Crystal edge detect
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            xtal_prev_reg <= 1'b0;
        end else begin
            xtal_prev_reg <= xtal_in;
        end
    end
    assign xtick = xtal_in && !xtal_prev_reg;

    // ==========================================================
    // Write holding until the next crystal edge
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_reg      <= 1'b0;
            pend_addr_reg <= WIT_REG_RESET;
            pend_data_reg <= WIT_REG_RESET;
        end else if (sfr_wr_in && !pend_reg) begin
            pend_reg      <= 1'b1;
            pend_addr_reg <= sfr_addr_in;
            pend_data_reg <= sfr_wdata_in;
        end else if (xtick) begin
            pend_reg      <= 1'b0;
        end
    end
    assign apply        = pend_reg && xtick;
    assign sfr_busy_out = pend_reg;

    // ==========================================================
    // Interval step and match
    assign step     = xtick && ctrl_reg[WIT_BIT_TIME_CLOCK_ENABLE] && ctrl_reg[WIT_BIT_INTERVAL_COUNT_ENABLE]
                      && tif.ovf[ctrl_reg[WIT_BIT_TBLO +: 2]];
    assign match    = step && ((icnt_reg + 8'h01) == compare_reg);
    assign flag_clr = apply && (pend_addr_reg == WIT_ADDR_CTRL) && !pend_data_reg[WIT_BIT_FLAG];

    // Interval counter
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            icnt_reg <= WIT_REG_RESET;
        end else if (!ctrl_reg[WIT_BIT_INTERVAL_COUNT_ENABLE] || match) begin
            icnt_reg <= WIT_REG_RESET;
        end else if (step) begin
            icnt_reg <= icnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // Control register
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_reg <= WIT_CTRL_RESET;
        end else begin
            if (apply && pend_addr_reg == WIT_ADDR_CTRL) begin
                ctrl_reg[6:3] <= pend_data_reg[6:3];
                ctrl_reg[1:0] <= pend_data_reg[1:0];
            end
            if (match && ctrl_reg[WIT_BIT_STI]) begin
                ctrl_reg[WIT_BIT_INTERVAL_COUNT_ENABLE] <= 1'b0;
            end
            if (match) begin
                ctrl_reg[WIT_BIT_FLAG] <= 1'b1;
            end else if (flag_clr) begin
                ctrl_reg[WIT_BIT_FLAG] <= 1'b0;
            end
        end
    end

    // Compare value
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            compare_reg <= WIT_REG_RESET;
        end else if (apply && pend_addr_reg == WIT_ADDR_COMPARE) begin
            compare_reg <= pend_data_reg;
        end
    end

    // ==========================================================
    // Time register shadows and loads
    genvar i;
    generate
        for (i = 0; i < WIT_STAGES; i++) begin : g_shadow
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    shadow_reg[i] <= WIT_REG_RESET;
                end else if (apply && pend_addr_reg == WIT_ADDR_HTHSEC + 8'(i)) begin
                    shadow_reg[i] <= pend_data_reg;
                end
            end
            assign tif.shadow[i] = shadow_reg[i];
            assign tif.ld[i]     = apply && (pend_addr_reg == WIT_ADDR_HTHSEC + 8'(i));
        end
    endgenerate
    assign tif.xtick  = xtick;
    assign tif.run    = ctrl_reg[WIT_BIT_TIME_CLOCK_ENABLE];
    assign tif.twenty_four_hour_select    = ctrl_reg[WIT_BIT_TFH];
    assign tif.ld_val = pend_data_reg;

    wit_time_chain u_chain (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .tif     (tif)
    );

    // ==========================================================
    // Read data
    always_comb begin
        unique case (sfr_addr_in)
            WIT_ADDR_CTRL:    rd_mux = {1'b0, ctrl_reg[6:0]};
            WIT_ADDR_HTHSEC:  rd_mux = tif.count[0];
            WIT_ADDR_SEC:     rd_mux = tif.count[1];
            WIT_ADDR_MIN:     rd_mux = tif.count[2];
            WIT_ADDR_HOUR:    rd_mux = tif.count[3];
            WIT_ADDR_COMPARE: rd_mux = compare_reg;
            default:          rd_mux = WIT_REG_RESET;
        endcase
    end
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sfr_rdata_out <= WIT_REG_RESET;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= rd_mux;
        end
    end

    // ==========================================================
    // Interrupt request and wake
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out         <= 1'b0;
            wake_out        <= 1'b0;
            wake_vector_out <= 16'h0000;
        end else begin
            irq_out         <= ctrl_reg[WIT_BIT_FLAG] && irq_enable_in;
            wake_out        <= ctrl_reg[WIT_BIT_FLAG] && irq_enable_in && power_down_in;
            wake_vector_out <= WIT_WAKE_VECTOR;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_timeout;
        match && !flag_clr;
    endsequence
    sequence s_single_timeout;
        match && ctrl_reg[WIT_BIT_STI];
    endsequence

    chk_match_sets_flag: assert property (s_timeout |=> ctrl_reg[WIT_BIT_FLAG]
        ##1 (irq_out == $past(irq_enable_in)))
        else $error("match did not set flag");
    chk_single_stops: assert property (s_single_timeout |=> !ctrl_reg[WIT_BIT_INTERVAL_COUNT_ENABLE] && icnt_reg == 8'h00)
        else $error("single interval did not stop");
    chk_auto_reload: assert property (match && !ctrl_reg[WIT_BIT_STI] && !apply
        |=> ctrl_reg[WIT_BIT_INTERVAL_COUNT_ENABLE] && icnt_reg == 8'h00)
        else $error("interval counter not reloaded");
    chk_step_on_edge: assert property (!xtick && ctrl_reg[WIT_BIT_INTERVAL_COUNT_ENABLE] |=> $stable(icnt_reg))
        else $error("interval counter moved off crystal edge");
    chk_write_waits: assert property (pend_reg && !xtick |=> pend_reg && $stable(pend_data_reg))
        else $error("pending write lost before crystal edge");
    chk_irq_hold: assert property (ctrl_reg[WIT_BIT_FLAG] && irq_enable_in |=> irq_out)
        else $error("interrupt not raised with flag and enable");
    chk_wake_vector: assert property (ctrl_reg[WIT_BIT_FLAG] && irq_enable_in && power_down_in
        |=> wake_out && wake_vector_out == WIT_WAKE_VECTOR)
        else $error("power-down match did not wake");
    chk_flag_clear: assert property (flag_clr && !match |=> !ctrl_reg[WIT_BIT_FLAG])
        else $error("flag not cleared by zero write");
    chk_ctrl_bit7: assert property (sfr_rd_in && sfr_addr_in == WIT_ADDR_CTRL |=> !sfr_rdata_out[7])
        else $error("reserved control bit read as one");
endmodule

// file: sim/wakeup_interval_timer_tb_top.sv
// Self-checking bench for the wake-up interval timer.
// Assumes the design files under logic/ are compiled first.
`timescale 1ns/10ps
module wakeup_interval_timer_tb_top
    import wit_pkg::*;
;
    // ====================
    // Signals and counters
    localparam int TICK = 2048;    // Core cycles per 1/128 s with the fast crystal below
    logic        mclk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        xtal_in = 1'b0;
    logic [7:0]  sfr_addr_in = 8'h00;
    logic [7:0]  sfr_wdata_in = 8'h00;
    logic        sfr_wr_in = 1'b0;
    logic        sfr_rd_in = 1'b0;
    logic        irq_enable_in = 1'b0;
    logic        power_down_in = 1'b0;
    logic [7:0]  sfr_rdata_out;
    logic        sfr_busy_out;
    logic        irq_out;
    logic        wake_out;
    logic [15:0] wake_vector_out;
    logic [7:0]  v;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          n;
    int          c;

    // ====================
    // Device under test
    wit_timer uut (
        .mclk_in         (mclk_in),
        .rstn_in         (rstn_in),
        .xtal_in         (xtal_in),
        .sfr_addr_in     (sfr_addr_in),
        .sfr_wdata_in    (sfr_wdata_in),
        .sfr_wr_in       (sfr_wr_in),
        .sfr_rd_in       (sfr_rd_in),
        .sfr_rdata_out   (sfr_rdata_out),
        .sfr_busy_out    (sfr_busy_out),
        .irq_enable_in   (irq_enable_in),
        .power_down_in   (power_down_in),
        .irq_out         (irq_out),
        .wake_out        (wake_out),
        .wake_vector_out (wake_vector_out)
    );

    // Core clock, and a crystal sped up so a tick stays short
    always #10 mclk_in = ~mclk_in;
    always #80 xtal_in = ~xtal_in;

    // Hang guard
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles >= 80000) begin
            bad_count++;
            $display("BAD t=%0t run too long", $time);
            results();
        end
    end

    // ====================
    // Tasks
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // Expected hour after one minutes wrap, from the hour select
    function automatic logic [7:0] next_hour(input logic [7:0] h, input logic twenty_four_hour_select);
        if (twenty_four_hour_select && h == WIT_HOUR24_MAX) begin
            return 8'h00;
        end
        return h + 8'h01;
    endfunction

    // Expected control readback after a timeout
    function automatic logic [7:0] ctrl_after_match(input logic [7:0] ctrl);
        logic [7:0] r;
        r = ctrl;
        r[WIT_BIT_FLAG] = 1'b1;
        if (ctrl[WIT_BIT_STI]) begin
            r[WIT_BIT_INTERVAL_COUNT_ENABLE] = 1'b0;
        end
        return r;
    endfunction

    task automatic step();
        @(posedge mclk_in);
        #1;
    endtask

    // Read strobe stays up so back-to-back reads never pulse it in one time step
    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        sfr_addr_in = addr;
        sfr_rd_in = 1'b1;
        step();
        data = sfr_rdata_out;
    endtask

    // Waits out any slow write first, then waits for its own to land
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        int k;
        k = 0;
        while (sfr_busy_out !== 1'b0 && k < 4000) begin
            step();
            k++;
        end
        sfr_rd_in = 1'b0;
        sfr_addr_in = addr;
        sfr_wdata_in = data;
        sfr_wr_in = 1'b1;
        step();
        sfr_wr_in = 1'b0;
        k = 0;
        while (sfr_busy_out !== 1'b0 && k < 4000) begin
            step();
            k++;
        end
        check_bit(sfr_busy_out, 1'b0, "write done");
    endtask

    task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        sfr_read(addr, d);
        check_val(16'(d), 16'(exp), "read");
    endtask

    task automatic wait_flag(output int k);
        logic [7:0] d;
        k = 0;
        do begin
            sfr_read(WIT_ADDR_CTRL, d);
            k++;
        end while (d[WIT_BIT_FLAG] !== 1'b1 && k < 9000);
    endtask

    // Preload the time chain with stopped clock
    task automatic preload(input logic [7:0] h, input logic [7:0] s, input logic [7:0] m, input logic [7:0] r);
        sfr_write(WIT_ADDR_HTHSEC, h);
        sfr_write(WIT_ADDR_SEC, s);
        sfr_write(WIT_ADDR_MIN, m);
        sfr_write(WIT_ADDR_HOUR, r);
    endtask

    // ====================
    // Main sequence
    initial begin
        void'($urandom(86592));
        repeat (2) @(posedge mclk_in);
        #1 rstn_in = 1'b1;
        step();
        check_val(wake_vector_out, 16'h0053, "vector");
        for (int a = 8'hA1; a <= 8'hA7; a++) begin
            read_chk(8'(a), 8'h00);
        end
        $display("test reset done");

        // Readback of preloaded seconds and compare values
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom_range(59, 0));
            preload(8'($urandom_range(127, 0)), v, v, 8'($urandom));
            read_chk(WIT_ADDR_SEC, v);
            v = 8'($urandom);
            sfr_write(WIT_ADDR_COMPARE, v);
            read_chk(WIT_ADDR_COMPARE, v);
        end
        // A write during busy is dropped
        sfr_rd_in = 1'b0;
        sfr_addr_in = WIT_ADDR_COMPARE;
        sfr_wdata_in = 8'h5A;
        sfr_wr_in = 1'b1;
        step();
        sfr_wdata_in = 8'hA5;
        check_bit(sfr_busy_out, 1'b1, "busy");
        step();
        sfr_wr_in = 1'b0;
        step();
        sfr_write(WIT_ADDR_CTRL, 8'h80);
        read_chk(WIT_ADDR_COMPARE, 8'h5A);
        read_chk(WIT_ADDR_CTRL, 8'h00);
        $display("test registers done");

        // Interval at 1/128 s, single shot then auto reload
        for (int i = 0; i < 2; i++) begin
            c = $urandom_range(3, 1);
            v = i ? 8'h03 : 8'h0B;
            irq_enable_in = i[0];
            power_down_in = 1'b1;
            sfr_write(WIT_ADDR_COMPARE, 8'(c));
            sfr_write(WIT_ADDR_CTRL, v);
            wait_flag(n);
            check_bit(n > c * TICK - 64 && n < c * TICK + 64, 1'b1, "interval");
            step();
            check_bit(irq_out, i[0], "irq");
            check_bit(wake_out, i[0], "wake");
            // Leaving power-down drops the wake request but not the interrupt
            power_down_in = 1'b0;
            step();
            check_bit(wake_out, 1'b0, "awake");
            check_bit(irq_out, i[0], "irq awake");
            read_chk(WIT_ADDR_CTRL, ctrl_after_match(v));
            if (i == 1) begin
                // Writing one to the flag leaves it set
                sfr_write(WIT_ADDR_CTRL, 8'h07);
                read_chk(WIT_ADDR_CTRL, 8'h07);
                sfr_write(WIT_ADDR_CTRL, 8'h03);
                wait_flag(n);
                check_bit(n > c * TICK - 128 && n < c * TICK + 64, 1'b1, "reload");
            end
            sfr_write(WIT_ADDR_CTRL, 8'h00);
            step();
            check_bit(irq_out, 1'b0, "irq clear");
        end
        $display("test interval done");

        // Each slower timebase fires one tick after its stage is preloaded to wrap
        for (int tb = 1; tb < 4; tb++) begin
            preload(8'h7F, tb > 1 ? 8'h3B : 8'($urandom_range(58, 0)),
                    tb > 2 ? 8'h3B : 8'($urandom_range(58, 0)), 8'h03);
            sfr_write(WIT_ADDR_COMPARE, 8'h01);
            sfr_write(WIT_ADDR_CTRL, 8'(tb << 4) | 8'h0B);
            wait_flag(n);
            check_bit(n > TICK - 64 && n < TICK + 64, 1'b1, "timebase");
            sfr_write(WIT_ADDR_CTRL, 8'h00);
            // The restore lands one edge after the enable falls
            step();
            read_chk(WIT_ADDR_HTHSEC, 8'h7F);
        end
        $display("test timebase done");

        // Hour wrap with and without the 24-hour select
        for (int t = 0; t < 2; t++) begin
            preload(8'h7F, 8'h3B, 8'h3B, 8'h17);
            sfr_write(WIT_ADDR_CTRL, t ? 8'h41 : 8'h01);
            n = 0;
            do begin
                sfr_read(WIT_ADDR_HOUR, v);
                n++;
            end while (v === 8'h17 && n < TICK + 64);
            check_val(16'(v), 16'(next_hour(8'h17, t[0])), "hour");
            sfr_write(WIT_ADDR_CTRL, 8'h00);
        end
        $display("test hours done");

        // Reset in mid-run
        sfr_write(WIT_ADDR_CTRL, 8'h03);
        rstn_in = 1'b0;
        step();
        rstn_in = 1'b1;
        step();
        check_val(wake_vector_out, 16'h0053, "vector after reset");
        check_bit(irq_out, 1'b0, "irq after reset");
        read_chk(WIT_ADDR_CTRL, 8'h00);
        $display("test second reset done");
        results();
    end
endmodule
